// ---- rtl/cpt_pkg.sv ----
// Constants, register map and types shared by the carrier timer files
package cpt_pkg;

    // ==========================================================
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] CPT_OFF_MODE = 8'h00;
    localparam logic [7:0] CPT_OFF_LOW  = 8'h04;
    localparam logic [7:0] CPT_OFF_HIGH = 8'h08;
    localparam logic [7:0] CPT_OFF_DUTY = 8'h0c;
    localparam logic [7:0] CPT_OFF_PORT = 8'h10;
    localparam logic [7:0] CPT_OFF_STAT = 8'h14;

    // ==========================================================
    // Field positions
    localparam int CPT_MODE_RUN_BIT   = 7;
    localparam int CPT_MODE_CKS_LSB   = 4;
    localparam int CPT_MODE_CSEL_BIT  = 0;
    localparam int CPT_PORT_DIR_BIT   = 0;
    localparam int CPT_PORT_LATCH_BIT = 1;
    localparam int CPT_STAT_OUT_BIT   = 0;
    localparam int CPT_STAT_PH_BIT    = 1;
    localparam int CPT_STAT_PEND_BIT  = 2;
    localparam int CPT_STAT_CNT_LSB   = 8;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] CPT_RST_CMP   = 8'h00;
    localparam logic [2:0] CPT_RST_CKS   = 3'h0;
    localparam logic       CPT_RST_DIR   = 1'b1;
    localparam logic       CPT_RST_LATCH = 1'b0;

    // ==========================================================
    // Counts
    localparam logic [1:0] CPT_HIGH_LOAD_TICKS = 2'd3;
    localparam int         CPT_PRE_W           = 16;

    // Phase of the carrier waveform, one-hot
    typedef enum logic [1:0] {
        CPT_PH_LOW  = 2'b01,
        CPT_PH_HIGH = 2'b10
    } cpt_phase_t;

endpackage : cpt_pkg

// ---- rtl/cpt_prescaler.sv ----
// Count-clock enable generator, divides the peripheral clock by a power of four
`timescale 1ns/1ps
module cpt_prescaler
    import cpt_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    // Select and enable
    input  wire logic [2:0] cks_i,
    output logic            tick_o
);

    typedef struct packed {
        logic [CPT_PRE_W-1:0] div;
    } cpt_pre_state_t;

    cpt_pre_state_t        s;
    cpt_pre_state_t        next_s;
    logic [CPT_PRE_W-1:0]  mask;

    // ==========================================================
    // Free divider; tick when the selected low bits are all ones
    always_comb begin
        next_s     = s;
        next_s.div = s.div + 16'h0001;
        mask       = CPT_PRE_W'((32'h1 << {cks_i, 1'b0}) - 32'h1);
        tick_o     = &(s.div | ~mask); // see RL7
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Divide by four: a tick, three idle cycles, then the next tick
    chk_tick_spacing: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RL7
        (cks_i == 3'h1 && tick_o) |=> (cks_i != 3'h1 || !tick_o) ##1 (cks_i != 3'h1 || !tick_o)
            ##1 (cks_i != 3'h1 || !tick_o) ##1 (cks_i != 3'h1 || tick_o))
        else $error("count clock tick spacing wrong");

endmodule : cpt_prescaler

// ---- rtl/cpt_pin_mux.sv ----
// Output pin steering shared by the port latch and the timer output
`timescale 1ns/1ps
module cpt_pin_mux
    import cpt_pkg::*;
(
    // Port controls
    input  wire logic dir_i,
    input  wire logic latch_i,
    // Timer level
    input  wire logic tmr_i,
    // Pin drive
    output logic      pin_o,
    output logic      oe_o
);

    // ==========================================================
    // Direction 1 means input; latch must be 0 to pass the carrier
    always_comb begin
        oe_o  = ~dir_i;                      // see RL13
        pin_o = ~dir_i & (latch_i | tmr_i);  // see RL13
    end

endmodule : cpt_pin_mux

// ---- rtl/cpt_carrier_timer.sv ----
// Carrier and PWM timer with Wishbone register slave and pin drive
`timescale 1ns/1ps
//
// Function
// RL1: Carrier period is low compare plus high compare plus two count clocks.
// RL2: Carrier high phase lasts high compare plus one count clocks.
// RL3: Carrier low phase lasts low compare plus one, alternating while running.
// RL4: Software rewrites high compare every time the timer restarts.
// RL5: Software keeps both carrier compares between 01h and ffh.
// RL6: A high compare write reaches the active compare after three count clocks.
// RL7: The operating clock is chosen by the three-bit count clock select.
// RL8: Software sets carrier mode select before starting, never while counting.
// RL9: Clearing the run bit stops counting.
// RL10: Software keeps count clock above six times the companion counter clock.
// RL11: Software leaves first timer mode bits alone while that timer runs.
// RL12: Software rewrites the PWM duty compare on every restart.
// RL13: Pin level depends on direction bit, latch bit and timer output.
module cpt_carrier_timer
    import cpt_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Timer output and pin
    output logic             carrier_o,
    output logic             pin_o,
    output logic             pin_oe_o
);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic        run;
        logic [2:0]  cks;
        logic        csel;
        logic [7:0]  lowc;
        logic [7:0]  highc;
        logic [7:0]  pend;
        logic [1:0]  pcnt;
        logic [7:0]  mact;
        logic [7:0]  duty;
        logic [7:0]  cnt;
        cpt_phase_t  phase;
        logic        out;
        logic        dir;
        logic        latch;
        logic        pin;
        logic        pin_oe;
    } cpt_state_t;

    cpt_state_t  s;
    cpt_state_t  next_s;
    logic        tick;
    logic        req;
    logic        wr;
    logic        mode_wr;
    logic        high_wr;
    logic        cmp_wr;
    logic [7:0]  adr;
    logic [7:0]  wd;
    logic [31:0] rd;
    logic        mux_pin;
    logic        mux_oe;

    // ==========================================================
    // Sub-blocks
    cpt_prescaler u_pre (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .cks_i  (s.cks),
        .tick_o (tick)
    );

    cpt_pin_mux u_pin (
        .dir_i   (s.dir),
        .latch_i (s.latch),
        .tmr_i   (s.out),
        .pin_o   (mux_pin),
        .oe_o    (mux_oe)
    );

    // ==========================================================
    // Bus decode; unmapped reads return zero, writes are dropped
    always_comb begin
        adr     = {wb_adr_i[7:2], 2'b00};
        wd      = wb_dat_i[7:0];
        req     = wb_cyc_i & wb_stb_i & ~s.ack;
        wr      = req & wb_we_i & wb_sel_i[0];
        mode_wr = wr & (adr == CPT_OFF_MODE);
        high_wr = wr & (adr == CPT_OFF_HIGH);
        cmp_wr  = wr & ((adr == CPT_OFF_LOW) | high_wr);
        case (adr)
            CPT_OFF_MODE: rd = {24'h0, s.run, s.cks, 3'h0, s.csel};
            CPT_OFF_LOW:  rd = {24'h0, s.lowc};
            CPT_OFF_HIGH: rd = {24'h0, s.highc};
            CPT_OFF_DUTY: rd = {24'h0, s.duty};
            CPT_OFF_PORT: rd = {30'h0, s.latch, s.dir};
            CPT_OFF_STAT: rd = {16'h0, s.cnt, 5'h0, (s.pcnt != 2'd0),
                                (s.phase == CPT_PH_HIGH), s.out};
            default:      rd = 32'h0;
        endcase
    end

    // ==========================================================
    // Next state: registers, load pipe, counter, pin
    always_comb begin
        next_s      = s;
        next_s.ack  = req;
        next_s.rdat = (req & ~wb_we_i) ? rd : 32'h0;

        // Register writes take effect with the ack edge
        if (mode_wr) begin
            next_s.run  = wd[CPT_MODE_RUN_BIT];
            next_s.cks  = wd[CPT_MODE_CKS_LSB +: 3];  // see RL7
            next_s.csel = wd[CPT_MODE_CSEL_BIT];
        end
        if (wr && adr == CPT_OFF_LOW) begin
            next_s.lowc = wd;
        end
        if (wr && adr == CPT_OFF_DUTY) begin
            next_s.duty = wd;
        end
        if (wr && adr == CPT_OFF_PORT) begin
            next_s.dir   = wd[CPT_PORT_DIR_BIT];
            next_s.latch = wd[CPT_PORT_LATCH_BIT];
        end

        // High compare passes a three-tick pipe before use
        if (high_wr) begin
            next_s.highc = wd;
            next_s.pend  = wd;
            next_s.pcnt  = CPT_HIGH_LOAD_TICKS;       // see RL6
        end else if (tick && s.pcnt != 2'd0) begin
            next_s.pcnt = s.pcnt - 2'd1;
            if (s.pcnt == 2'd1) begin
                next_s.mact = s.pend;                 // see RL6
            end
        end

        // Stopped timer holds a clean start point
        if (!next_s.run) begin
            next_s.cnt   = 8'h00;                     // see RL9
            next_s.phase = CPT_PH_LOW;
            next_s.out   = 1'b0;                      // see RL9
        end else if (tick && s.run) begin
            if (s.csel) begin
                case (s.phase) // see RL1
                    CPT_PH_LOW: begin
                        if (s.cnt >= s.lowc) begin    // see RL3
                            next_s.cnt   = 8'h00;
                            next_s.phase = CPT_PH_HIGH;
                            next_s.out   = 1'b1;
                        end else begin
                            next_s.cnt = s.cnt + 8'h01;
                        end
                    end
                    CPT_PH_HIGH: begin
                        // Greater-or-equal guards a compare shrunk mid-phase
                        if (s.cnt >= s.mact) begin    // see RL2
                            next_s.cnt   = 8'h00;
                            next_s.phase = CPT_PH_LOW;
                            next_s.out   = 1'b0;
                        end else begin
                            next_s.cnt = s.cnt + 8'h01;
                        end
                    end
                    default: begin
                        next_s.cnt   = 8'h00;
                        next_s.phase = CPT_PH_LOW;
                        next_s.out   = 1'b0;
                    end
                endcase
            end else begin
                // PWM: period low compare plus one, high for duty plus one
                next_s.cnt   = (s.cnt >= s.lowc) ? 8'h00 : s.cnt + 8'h01;
                next_s.out   = (next_s.cnt <= s.duty);
                next_s.phase = next_s.out ? CPT_PH_HIGH : CPT_PH_LOW;
            end
        end

        // Pin drive registered so outputs come from flops
        next_s.pin    = mux_pin;                      // see RL13
        next_s.pin_oe = mux_oe;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s        <= '0;
            s.lowc   <= CPT_RST_CMP;
            s.highc  <= CPT_RST_CMP;
            s.pend   <= CPT_RST_CMP;
            s.mact   <= CPT_RST_CMP;
            s.duty   <= CPT_RST_CMP;
            s.cks    <= CPT_RST_CKS;
            s.phase  <= CPT_PH_LOW;
            s.dir    <= CPT_RST_DIR;
            s.latch  <= CPT_RST_LATCH;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign wb_ack_o  = s.ack;
    assign wb_dat_o  = s.rdat;
    assign carrier_o = s.out;
    assign pin_o     = s.pin;
    assign pin_oe_o  = s.pin_oe;

    // ==========================================================
    // Checks; helper counts ticks between carrier rises
    logic [9:0] per_cnt;
    logic       per_ok;
    logic       out_d;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            per_cnt <= 10'h000;
            per_ok  <= 1'b0;
            out_d   <= 1'b0;
        end else begin
            out_d <= s.out;
            if (!s.run || !s.csel || cmp_wr || s.pcnt != 2'd0) begin
                per_cnt <= 10'h000;
                per_ok  <= 1'b0;
            end else if (s.out && !out_d) begin
                per_cnt <= {9'h000, tick};
                per_ok  <= 1'b1;
            end else begin
                per_cnt <= per_cnt + {9'h000, tick};
            end
        end
    end

    default clocking cpt_cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_carrier_period: assert property ( // see RL1
        (s.out && !out_d && per_ok && s.pcnt == 2'd0 && !cmp_wr)
        |-> per_cnt == {2'b00, s.lowc} + {2'b00, s.mact} + 10'd2)
        else $error("carrier period not low plus high plus two");

    chk_high_end: assert property ( // see RL2
        (s.run && s.csel && !mode_wr && tick && s.phase == CPT_PH_HIGH && s.cnt == s.mact)
        |=> !s.out && s.phase == CPT_PH_LOW && s.cnt == 8'h00)
        else $error("high phase did not end at high compare");

    chk_low_end: assert property ( // see RL3
        (s.run && s.csel && !mode_wr && tick && s.phase == CPT_PH_LOW && s.cnt == s.lowc)
        |=> s.out && s.phase == CPT_PH_HIGH && s.cnt == 8'h00)
        else $error("low phase did not end at low compare");

    chk_high_load: assert property ( // see RL6
        high_wr |=> s.pcnt == 2'd3 && s.mact == $past(s.mact))
        else $error("high compare write not delayed");

    chk_high_commit: assert property ( // see RL6
        (s.pcnt == 2'd1 && tick && !high_wr) |=> s.mact == $past(s.pend) && s.pcnt == 2'd0)
        else $error("high compare not committed on third tick");

    chk_stop_clears: assert property ( // see RL9
        (mode_wr && !wb_dat_i[CPT_MODE_RUN_BIT]) |=> !s.run && !s.out && s.cnt == 8'h00)
        else $error("clearing run did not stop the timer");

    chk_pin_follow: assert property ( // see RL13
        ##1 (pin_oe_o == !$past(s.dir)) && (pin_o == (!$past(s.dir) && ($past(s.latch) || $past(s.out)))))
        else $error("pin does not follow direction, latch and timer");

    // Phase bodies: below the compare the counter steps by one and the level holds
    chk_low_step: assert property ( // see RL3
        (s.run && s.csel && !mode_wr && tick && s.phase == CPT_PH_LOW && s.cnt < s.lowc)
        |=> !s.out && s.phase == CPT_PH_LOW && s.cnt == $past(s.cnt) + 8'h01)
        else $error("low phase counter did not step");

    chk_high_step: assert property ( // see RL2
        (s.run && s.csel && !mode_wr && tick && s.phase == CPT_PH_HIGH && s.cnt < s.mact)
        |=> s.out && s.phase == CPT_PH_HIGH && s.cnt == $past(s.cnt) + 8'h01)
        else $error("high phase counter did not step");

    // Counter and level move only on a count clock tick or a mode write
    chk_count_hold: assert property ( // see RL7
        (!tick && !mode_wr) |=> $stable(s.cnt) && $stable(s.out))
        else $error("counter moved without a count clock tick");

    chk_stop_idle: assert property ( // see RL9
        !s.run |-> !s.out && s.cnt == 8'h00 && s.phase == CPT_PH_LOW)
        else $error("stopped timer not idle");

    // Write pipe: the new value waits, the active copy holds between ticks
    chk_high_capture: assert property ( // see RL6
        high_wr |=> s.highc == $past(wd) && s.pend == $past(wd))
        else $error("high compare write not captured");

    chk_pipe_hold: assert property ( // see RL6
        (s.pcnt != 2'd0 && !tick && !high_wr) |=> $stable(s.pcnt) && $stable(s.mact))
        else $error("high compare pipe moved without a tick");

endmodule : cpt_carrier_timer

// ---- verif/cpt_carrier_rx.sv ----
// Far-side model: carrier receiver that measures pin pulse widths
`timescale 1ns/1ps
module cpt_carrier_rx (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    // Pin drive from the timer
    input  wire logic        pin_i,
    input  wire logic        oe_i,
    // Last measured widths in clocks
    output logic      [15:0] high_len_o,
    output logic      [15:0] low_len_o
);
    logic        lvl;
    logic        prev;
    logic [15:0] run;

    // ==========================================================
    // Undriven pin settles to the pull-down level
    assign lvl = oe_i ? pin_i : 1'b0;

    // Run length of each level, latched when the level turns
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run        <= 16'h0000;
            prev       <= 1'b0;
            high_len_o <= 16'h0000;
            low_len_o  <= 16'h0000;
        end else begin
            prev <= lvl;
            run  <= (lvl != prev) ? 16'h0001 : run + 16'h0001;
            if (lvl != prev && prev) begin
                high_len_o <= run;
            end
            if (lvl != prev && !prev) begin
                low_len_o <= run;
            end
        end
    end
endmodule : cpt_carrier_rx

// ---- verif/cpt_carrier_timer_test.sv ----
// Testbench for the carrier timer: bus, waveform widths and pin steering
`timescale 1ns/1ps
module cpt_carrier_timer_test;
    import cpt_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [7:0]  adr    = 8'h00;
    logic [3:0]  sel    = 4'h0;
    logic [31:0] dat    = 32'h0;
    logic [31:0] q;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, carrier_o, pin_o, pin_oe_o;
    logic [15:0] hi, lo;
    int          n_errors = 0;
    int          n_tests  = 0;

    // ==========================================================
    // Clock, design and far-side model
    always #10 mclk_i = ~mclk_i;
    cpt_carrier_timer i_cpt_carrier_timer (.mclk_i(mclk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .carrier_o(carrier_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    cpt_carrier_rx i_cpt_carrier_rx (.mclk_i(mclk_i), .rstn_i(rstn_i), .pin_i(pin_o), .oe_i(pin_oe_o),
        .high_len_o(hi), .low_len_o(lo));

    // ==========================================================
    // Shared tasks
    task final_report;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // Classic cycle; request held until ack is sampled high
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (k >= 50) chk(32'h0, 32'h1, "no ack");
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task cyc_wait(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc_wait

    // ==========================================================
    // Scenarios
    task t_reset;
        bus(1'b0, CPT_OFF_MODE, 32'h0);
        chk(q, {24'h0, 1'b0, CPT_RST_CKS, 4'h0}, "reset mode");
        bus(1'b0, CPT_OFF_LOW, 32'h0);
        chk(q, {24'h0, CPT_RST_CMP}, "reset low");
        bus(1'b0, CPT_OFF_HIGH, 32'h0);
        chk(q, {24'h0, CPT_RST_CMP}, "reset high");
        bus(1'b0, CPT_OFF_DUTY, 32'h0);
        chk(q, {24'h0, CPT_RST_CMP}, "reset duty");
        bus(1'b0, CPT_OFF_PORT, 32'h0);
        chk(q, {30'h0, CPT_RST_LATCH, CPT_RST_DIR}, "reset port");
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0, "unmapped read");
        chk(pin_oe_o, 1'b0, "pin released");
        $display("t_reset done");
    endtask : t_reset

    task t_carrier;
        wr(CPT_OFF_LOW, 32'h2);
        wr(CPT_OFF_HIGH, 32'h4);
        wr(CPT_OFF_PORT, 32'h0);
        // Fastest count clock keeps well above the companion counter
        wr(CPT_OFF_MODE, 32'h81);
        cyc_wait(40);
        chk(hi, 16'd5, "high width");
        chk(lo, 16'd3, "low width");
        chk(hi + lo, 16'd8, "period");
        $display("t_carrier done");
    endtask : t_carrier

    task t_stop;
        logic bad;
        bad = 1'b0;
        wr(CPT_OFF_MODE, 32'h00);
        cyc_wait(2);
        // Any high level after stop is a fault
        repeat (30) begin
            @(posedge mclk_i);
            bad = bad | (carrier_o !== 1'b0);
        end
        chk(bad, 1'b0, "output after stop");
        $display("t_stop done");
    endtask : t_stop

    // Divide by four, then a live high compare change
    task t_clksel_load;
        wr(CPT_OFF_LOW, 32'h1);
        wr(CPT_OFF_HIGH, 32'h1);
        wr(CPT_OFF_MODE, 32'h91);
        cyc_wait(60);
        chk(hi, 16'd8, "high at div4");
        chk(lo, 16'd8, "low at div4");
        wr(CPT_OFF_HIGH, 32'h5);
        bus(1'b0, CPT_OFF_STAT, 32'h0);
        chk(q[CPT_STAT_PEND_BIT], 1'b1, "load pending");
        cyc_wait(20);
        bus(1'b0, CPT_OFF_STAT, 32'h0);
        chk(q[CPT_STAT_PEND_BIT], 1'b0, "load done");
        cyc_wait(80);
        chk(hi, 16'd24, "new high");
        chk(lo, 16'd8, "low kept");
        wr(CPT_OFF_MODE, 32'h00);
        $display("t_clksel_load done");
    endtask : t_clksel_load

    // PWM mode: period low compare plus one, high duty plus one
    task t_pwm;
        wr(CPT_OFF_DUTY, 32'h1);
        wr(CPT_OFF_LOW, 32'h4);
        wr(CPT_OFF_MODE, 32'h80);
        // Same-value mode refresh while running must not disturb counting
        wr(CPT_OFF_MODE, 32'h80);
        cyc_wait(40);
        chk(hi, 16'd2, "pwm high");
        chk(lo, 16'd3, "pwm low");
        wr(CPT_OFF_MODE, 32'h00);
        $display("t_pwm done");
    endtask : t_pwm

    task t_pin;
        wr(CPT_OFF_PORT, 32'h2);
        cyc_wait(2);
        chk({pin_oe_o, pin_o}, 2'b11, "latch high");
        wr(CPT_OFF_PORT, 32'h3);
        cyc_wait(2);
        chk(pin_oe_o, 1'b0, "input mode");
        wr(CPT_OFF_PORT, 32'h0);
        cyc_wait(2);
        chk({pin_oe_o, pin_o}, 2'b10, "timer low");
        $display("t_pin done");
    endtask : t_pin

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        cyc_wait(12);
        rstn_i <= 1'b1;
        t_reset();
        t_carrier();
        t_stop();
        t_clksel_load();
        t_pwm();
        t_pin();
        final_report();
    end

    initial begin
        #200000;
        n_errors++;
        $display("Error %0t: watchdog expired", $time);
        final_report();
    end
endmodule : cpt_carrier_timer_test
